// [hdl/channel_trigger_status_regs.sv]
// channel trigger control, general status and comparator status registers
//
// What this block does
// - a 1 written to a channel's comparator flag clear bit pulses a reset of its latched window output, and 0 does nothing.
// - a 1 written to a channel's margin low trigger bit pulses a margin low command on that channel for one cycle, and 0 does nothing.
// - a 1 written to a channel's margin high trigger bit pulses a margin high command on that channel for one cycle, and 0 does nothing.
// - each channel's waveform run bit is stored, read back, starts generation when 1 and stops it when 0.
// - the trigger register sits at 21h and resets to 0000h.
// - bit 15 of general status flags a failed factory load check and clears on software reset or power reset.
// - bit 14 of general status flags a failed user load check, blocks nothing, and clears on software reset.
// - bits 12 to 9 of general status show busy for channels 3 to 0, and margin and run commands to a busy channel are dropped, while flag clear still acts.
// - general status at 22h carries a 6 bit part identifier in bits 7-2 and a 2 bit revision identifier in bits 1-0, with bits 13 and 8 zero.
// - comparator status at 23h resets to 0000h and holds protect in bit 8, window outputs in 7-4 and comparator flags in 3-0.
// - in pmbus mode the three registers answer on page FFh at codes E5h, E6h and E7h.
// - the protect flag reads 1 once protect runs or has run and clears when comparator status is read.
// - each comparator flag is that channel's comparator output passed through a two flip-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none

module channel_trigger_status_regs #(
	// identifier values are arbitrary
	parameter logic [5:0] PART_ID = 6'h15,
	parameter logic [1:0] REV_ID = 2'h3
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic soft_reset_i,
	// register port from the serial interface
	input wire trig_status_pkg::reg_req_t req_i,
	output logic [trig_status_pkg::DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// channel commands
	output trig_status_pkg::chan_cmd_t chan_cmd_o,
	// channel and device state
	input wire logic [trig_status_pkg::NUM_CH-1:0] chan_busy_i,
	input wire logic factory_load_crc_error_i,
	input wire logic user_load_crc_error_i,
	input wire logic protect_active_i,
	input wire logic window_latch_en_i,
	// comparator pins, asynchronous
	input wire logic [trig_status_pkg::NUM_CH-1:0] compare_raw_i,
	input wire logic [trig_status_pkg::NUM_CH-1:0] window_raw_i
);

	import trig_status_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// address decode

	wire page_ok = (req_i.page == PMBUS_PAGE);
	wire pm = req_i.pmbus_mode;
	wire hit_trig = pm ? (page_ok && req_i.addr == PMBUS_TRIG)
		: (req_i.addr == ADDR_TRIG);
	wire hit_gstat = pm ? (page_ok && req_i.addr == PMBUS_GSTAT)
		: (req_i.addr == ADDR_GSTAT);
	wire hit_cstat = pm ? (page_ok && req_i.addr == PMBUS_CSTAT)
		: (req_i.addr == ADDR_CSTAT);

	reg_sel_t sel;
	assign sel = hit_trig ? SEL_TRIG
		: hit_gstat ? SEL_GSTAT
		: hit_cstat ? SEL_CSTAT
		: SEL_NONE;

	wire trig_wr = req_i.wr && (sel == SEL_TRIG);
	wire cstat_rd = req_i.rd && (sel == SEL_CSTAT);

	////////////////////////////////////////////////////////////////////////
	// trigger register fields

	logic [NUM_CH-1:0] wr_clear;
	logic [NUM_CH-1:0] wr_lo;
	logic [NUM_CH-1:0] wr_hi;
	logic [NUM_CH-1:0] wr_run;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++)
		begin : g_field
			localparam int B = CH0_NIBBLE_LSB - NIBBLE_W * ch;
			assign wr_clear[ch] = req_i.wdata[B + POS_CLEAR];
			assign wr_lo[ch] = req_i.wdata[B + POS_LO];
			assign wr_hi[ch] = req_i.wdata[B + POS_HI];
			assign wr_run[ch] = req_i.wdata[B + POS_RUN];
		end
	endgenerate

	chan_cmd_t cmd_reg;
	chan_cmd_t cmd_next;
	logic [NUM_CH-1:0] next_clear;
	logic [NUM_CH-1:0] next_lo;
	logic [NUM_CH-1:0] next_hi;
	logic [NUM_CH-1:0] next_run;

	// pulses last one cycle; margin commands to a busy channel are dropped
	// rather than queued, since a queued margin step could land late
	assign next_clear = trig_wr ? wr_clear : '0;
	assign next_lo = trig_wr ? (wr_lo & ~chan_busy_i) : '0;
	assign next_hi = trig_wr ? (wr_hi & ~chan_busy_i) : '0;
	// a busy channel keeps its run state
	assign next_run = trig_wr
		? ((wr_run & ~chan_busy_i) | (cmd_reg.run & chan_busy_i))
		: cmd_reg.run;
	assign cmd_next = '{next_clear, next_lo, next_hi, next_run};

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			cmd_reg <= TRIG_RESET;
		else
			cmd_reg <= cmd_next;
	end

	assign chan_cmd_o = cmd_reg;

	////////////////////////////////////////////////////////////////////////
	// comparator inputs

	logic [NUM_CH-1:0] cmp_sync;
	logic [NUM_CH-1:0] win_sync;
	logic [2*NUM_CH-1:0] both_sync;

	sync_bits #(
		.WIDTH(2 * NUM_CH)
	) u_sync (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({window_raw_i, compare_raw_i}),
		.sync_o(both_sync)
	);

	assign cmp_sync = both_sync[NUM_CH-1:0];
	assign win_sync = both_sync[2*NUM_CH-1:NUM_CH];

	logic [NUM_CH-1:0] win_latch_reg;
	logic [NUM_CH-1:0] win_latch_next;

	// a comparator trip in the clear cycle survives the clear
	assign win_latch_next = (win_latch_reg & ~cmd_reg.flag_clear) | win_sync;

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			win_latch_reg <= '0;
		else
			win_latch_reg <= win_latch_next;
	end

	wire [NUM_CH-1:0] win_view = window_latch_en_i ? win_latch_reg : win_sync;

	////////////////////////////////////////////////////////////////////////
	// sticky status flags

	logic factory_crc_reg;
	logic user_crc_reg;
	logic protect_reg;

	wire factory_crc_next = factory_load_crc_error_i
		| (factory_crc_reg & ~soft_reset_i);
	wire user_crc_next = user_load_crc_error_i
		| (user_crc_reg & ~soft_reset_i);
	wire protect_next = protect_active_i | (protect_reg & ~cstat_rd);

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			factory_crc_reg <= 1'b0;
			user_crc_reg <= 1'b0;
			protect_reg <= 1'b0;
		end
		else
		begin
			factory_crc_reg <= factory_crc_next;
			user_crc_reg <= user_crc_next;
			protect_reg <= protect_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read words

	reg_word_t trig_word;
	reg_word_t gstat_word;
	reg_word_t cstat_word;

	always_comb
	begin
		trig_word = WORD_ZERO;
		for (int i = 0; i < NUM_CH; i++)
			trig_word[CH0_NIBBLE_LSB - NIBBLE_W * i + POS_RUN] = cmd_reg.run[i];
	end

	always_comb
	begin
		gstat_word = WORD_ZERO;
		gstat_word[POS_FACTORY_CRC] = factory_crc_reg;
		gstat_word[POS_USER_CRC] = user_crc_reg;
		gstat_word[POS_BUSY_LSB +: NUM_CH] = chan_busy_i;
		gstat_word[POS_ID_LSB +: ID_W] = PART_ID;
		gstat_word[POS_REV_LSB +: REV_W] = REV_ID;
	end

	always_comb
	begin
		cstat_word = CSTAT_RESET;
		cstat_word[POS_PROTECT] = protect_reg;
		cstat_word[POS_WIN_LSB +: NUM_CH] = win_view;
		cstat_word[POS_CMP_LSB +: NUM_CH] = cmp_sync;
	end

	reg_word_t rdata_reg;
	reg_word_t rdata_next;
	logic rvalid_reg;

	always_comb
	begin
		case (sel)
			SEL_TRIG: rdata_next = trig_word;
			SEL_GSTAT: rdata_next = gstat_word;
			SEL_CSTAT: rdata_next = cstat_word;
			default: rdata_next = WORD_ZERO;
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			rdata_reg <= WORD_ZERO;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			if (req_i.rd)
				rdata_reg <= rdata_next;
			rvalid_reg <= req_i.rd;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	clear_pulse_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		trig_wr |=> chan_cmd_o.flag_clear == $past(wr_clear))
		else $error("flag clear pulse does not match write");

	self_clear_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!trig_wr |=> (chan_cmd_o.flag_clear == '0 && chan_cmd_o.margin_low == '0
			&& chan_cmd_o.margin_high == '0))
		else $error("trigger pulse held without a write");

	margin_low_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		trig_wr |=> chan_cmd_o.margin_low == ($past(wr_lo) & ~$past(chan_busy_i)))
		else $error("margin low pulse wrong");

	margin_high_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		trig_wr |=> chan_cmd_o.margin_high == ($past(wr_hi) & ~$past(chan_busy_i)))
		else $error("margin high pulse wrong");

	busy_refuse_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(trig_wr && chan_busy_i[0]) |=> (!chan_cmd_o.margin_low[0]
			&& !chan_cmd_o.margin_high[0] && $stable(chan_cmd_o.run[0])))
		else $error("busy channel took a command");

	run_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!trig_wr |=> $stable(chan_cmd_o.run))
		else $error("run bits changed without a write");

	run_readback_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(req_i.rd && sel == SEL_TRIG && !trig_wr) |=>
			reg_rdata_o[CH0_NIBBLE_LSB + POS_RUN] == chan_cmd_o.run[0]
			&& reg_rdata_o[POS_CLEAR] == 1'b0 && reg_rdata_o[POS_LO] == 1'b0)
		else $error("trigger readback wrong");

	factory_crc_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		factory_load_crc_error_i |=> factory_crc_reg)
		else $error("factory crc flag not set");

	factory_clear_a: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i)
		(soft_reset_i && !factory_load_crc_error_i) |=> !factory_crc_reg)
		else $error("factory crc flag not cleared");

	user_crc_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(soft_reset_i && !user_load_crc_error_i) |=> !user_crc_reg)
		else $error("user crc flag not cleared");

	ident_field_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(req_i.rd && sel == SEL_GSTAT) |=>
			reg_rdata_o[POS_ID_LSB +: ID_W] == PART_ID
			&& reg_rdata_o[POS_REV_LSB +: REV_W] == REV_ID)
		else $error("identifier fields wrong");

	protect_clear_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(cstat_rd && protect_reg && !protect_active_i) |=>
			(!protect_reg && reg_rdata_o[POS_PROTECT]))
		else $error("protect flag not read then cleared");

	cmp_sync_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$rose(compare_raw_i[0]) ##1 compare_raw_i[0] [*2] |-> cmp_sync[0])
		else $error("comparator flag not synchronised in two cycles");

	pmbus_map_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(req_i.pmbus_mode && req_i.page != PMBUS_PAGE) |-> sel == SEL_NONE)
		else $error("pmbus decode ignored the page");

endmodule
`default_nettype wire

// [hdl/sync_bits.sv]
// two flip-flop synchroniser for a group of independent level inputs
`timescale 1ns/1ps
`default_nettype none

module sync_bits #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// levels
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// meta_reg feeds sync_reg only
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;

endmodule
`default_nettype wire

// [hdl/trig_status_pkg.sv]
// constants, register map and carriers for the channel trigger/status bank
package trig_status_pkg;

	localparam int NUM_CH = 4;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;

	// native register addresses
	localparam logic [ADDR_W-1:0] ADDR_TRIG = 8'h21;
	localparam logic [ADDR_W-1:0] ADDR_GSTAT = 8'h22;
	localparam logic [ADDR_W-1:0] ADDR_CSTAT = 8'h23;

	// pmbus page and command codes
	localparam logic [ADDR_W-1:0] PMBUS_PAGE = 8'hFF;
	localparam logic [ADDR_W-1:0] PMBUS_TRIG = 8'hE5;
	localparam logic [ADDR_W-1:0] PMBUS_GSTAT = 8'hE6;
	localparam logic [ADDR_W-1:0] PMBUS_CSTAT = 8'hE7;

	// reset values
	localparam logic [DATA_W-1:0] TRIG_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] CSTAT_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;

	// trigger register: one nibble per channel, channel 0 at the top
	localparam int CH0_NIBBLE_LSB = 12;
	localparam int NIBBLE_W = 4;
	localparam int POS_CLEAR = 3;
	localparam int POS_LO = 2;
	localparam int POS_HI = 1;
	localparam int POS_RUN = 0;

	// general status layout
	localparam int POS_FACTORY_CRC = 15;
	localparam int POS_USER_CRC = 14;
	localparam int POS_BUSY_LSB = 9;
	localparam int POS_ID_LSB = 2;
	localparam int ID_W = 6;
	localparam int POS_REV_LSB = 0;
	localparam int REV_W = 2;

	// comparator status layout
	localparam int POS_PROTECT = 8;
	localparam int POS_WIN_LSB = 4;
	localparam int POS_CMP_LSB = 0;

	typedef logic [DATA_W-1:0] reg_word_t;

	typedef enum logic [3:0] {
		SEL_TRIG = 4'b0001,
		SEL_GSTAT = 4'b0010,
		SEL_CSTAT = 4'b0100,
		SEL_NONE = 4'b1000
	} reg_sel_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic pmbus_mode;
		logic [ADDR_W-1:0] page;
		logic wr;
		logic rd;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [NUM_CH-1:0] flag_clear;
		logic [NUM_CH-1:0] margin_low;
		logic [NUM_CH-1:0] margin_high;
		logic [NUM_CH-1:0] run;
	} chan_cmd_t;

endpackage

// [sim/channel_trigger_status_regs_tb.sv]
// self-checking bench for the trigger and status register bank
`timescale 1ns/1ps
`default_nettype none

module channel_trigger_status_regs_tb;
	import trig_status_pkg::*;

	// identifier values are arbitrary
	localparam logic [5:0] TB_PART = 6'h0B;
	localparam logic [1:0] TB_REV = 2'h3;
	localparam reg_word_t GID = {8'h00, TB_PART, TB_REV};

	logic core_clk_i;
	logic sys_rst_i;
	logic soft_reset_i;
	reg_req_t req;
	reg_word_t rdata;
	logic rvalid;
	chan_cmd_t cmd;
	logic [3:0] busy;
	logic fac_crc;
	logic usr_crc;
	logic protect;
	logic win_en;
	logic [3:0] cmp_raw;
	logic [3:0] win_raw;
	int failures;
	int n_checks;

	channel_trigger_status_regs #(
		.PART_ID(TB_PART),
		.REV_ID(TB_REV)
	) u_dut (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.soft_reset_i(soft_reset_i),
		.req_i(req),
		.reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid),
		.chan_cmd_o(cmd),
		.chan_busy_i(busy),
		.factory_load_crc_error_i(fac_crc),
		.user_load_crc_error_i(usr_crc),
		.protect_active_i(protect),
		.window_latch_en_i(win_en),
		.compare_raw_i(cmp_raw),
		.window_raw_i(win_raw)
	);

	host_reg_model u_host (
		.core_clk_i(core_clk_i),
		.req_o(req),
		.rdata_i(rdata),
		.rvalid_i(rvalid)
	);

	initial
	begin
		core_clk_i = 1'h0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	// write returns just after the taking edge, where pulses stand
	task automatic wr(input logic pm, input logic [7:0] a,
		input logic [15:0] d);
		logic [15:0] r;
		logic g;
		u_host.access(pm, PMBUS_PAGE, a, 1'h1, d, r, g);
	endtask

	task automatic rdc(input logic pm, input logic [7:0] a,
		input string name, input logic [15:0] exp);
		logic [15:0] r;
		logic g;
		u_host.access(pm, PMBUS_PAGE, a, 1'h0, 16'h0000, r, g);
		check(name, r, exp);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rdc(1'h0, ADDR_TRIG, "trig reset", TRIG_RESET);
		rdc(1'h0, ADDR_CSTAT, "cstat reset", CSTAT_RESET);
		rdc(1'h0, ADDR_GSTAT, "gstat reset", GID);
	endtask

	task automatic t_pulses();
		wr(1'h0, ADDR_TRIG, 16'h4001);
		check("cmd lo0 run3", cmd, 16'h0108);
		tick(1);
		check("cmd after", cmd, 16'h0008);
		rdc(1'h0, ADDR_TRIG, "trig rd", 16'h0001);
		wr(1'h0, ADDR_TRIG, 16'hEEEE);
		check("cmd all", cmd, 16'hFFF0);
		wr(1'h0, ADDR_TRIG, 16'h0000);
		check("cmd zero", cmd, 16'h0000);
		wr(1'h0, ADDR_TRIG, 16'h1111);
		rdc(1'h0, ADDR_TRIG, "run all", 16'h1111);
		check("run lvl", cmd, 16'h000F);
		wr(1'h0, ADDR_TRIG, 16'h0000);
		rdc(1'h0, ADDR_TRIG, "run off", 16'h0000);
	endtask

	task automatic t_unmapped();
		wr(1'h0, 8'h24, 16'hFFFF);
		check("cmd unmapped", cmd, 16'h0000);
		wr(1'h0, ADDR_GSTAT, 16'hFFFF);
		rdc(1'h0, ADDR_GSTAT, "gstat ro", GID);
		rdc(1'h0, 8'h24, "unmapped rd", 16'h0000);
	endtask

	// the host breaks the idle rule on purpose here
	task automatic t_busy();
		busy = 4'h1;
		wr(1'h0, ADDR_TRIG, 16'h6000);
		check("busy drop", cmd, 16'h0000);
		wr(1'h0, ADDR_TRIG, 16'h8000);
		check("busy clr", cmd, 16'h1000);
		rdc(1'h0, ADDR_GSTAT, "busy bit", GID | 16'h0200);
		busy = 4'h0;
	endtask

	task automatic t_crc();
		fac_crc = 1'h1;
		usr_crc = 1'h1;
		tick(1);
		fac_crc = 1'h0;
		usr_crc = 1'h0;
		rdc(1'h0, ADDR_GSTAT, "crc set", GID | 16'hC000);
		wr(1'h0, ADDR_TRIG, 16'h0002);
		check("crc allow", cmd, 16'h0080);
		tick(1);
		soft_reset_i = 1'h1;
		tick(1);
		soft_reset_i = 1'h0;
		rdc(1'h0, ADDR_GSTAT, "crc clr", GID);
	endtask

	task automatic t_protect();
		protect = 1'h1;
		tick(1);
		protect = 1'h0;
		rdc(1'h0, ADDR_CSTAT, "prot set", 16'h0100);
		rdc(1'h0, ADDR_CSTAT, "prot rdclr", 16'h0000);
	endtask

	task automatic t_compare();
		cmp_raw = 4'hB;
		win_raw = 4'h5;
		tick(3);
		rdc(1'h0, ADDR_CSTAT, "cmp live", 16'h005B);
		cmp_raw = 4'h0;
		win_en = 1'h1;
		win_raw = 4'h3;
		tick(3);
		win_raw = 4'h0;
		tick(3);
		// the latch also gathers trips seen while in live mode
		rdc(1'h0, ADDR_CSTAT, "win latch", 16'h0070);
		wr(1'h0, ADDR_TRIG, 16'h8888);
		check("clr pulse", cmd, 16'hF000);
		tick(2);
		rdc(1'h0, ADDR_CSTAT, "win clr", 16'h0000);
	endtask

	task automatic t_pmbus();
		logic [15:0] r;
		logic g;
		rdc(1'h1, PMBUS_GSTAT, "pm gstat", GID);
		wr(1'h1, PMBUS_TRIG, 16'h0001);
		rdc(1'h0, ADDR_TRIG, "pm trig", 16'h0001);
		protect = 1'h1;
		tick(1);
		protect = 1'h0;
		u_host.access(1'h1, 8'h00, PMBUS_CSTAT, 1'h0, 16'h0000, r, g);
		check("pm page", r, 16'h0000);
		rdc(1'h1, PMBUS_CSTAT, "pm cstat", 16'h0100);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		failures = 0;
		n_checks = 0;
		sys_rst_i = 1'h1;
		soft_reset_i = 1'h0;
		busy = 4'h0;
		fac_crc = 1'h0;
		usr_crc = 1'h0;
		protect = 1'h0;
		win_en = 1'h0;
		cmp_raw = 4'h0;
		win_raw = 4'h0;
		tick(20);
		sys_rst_i = 1'h0;
		t_reset();
		t_pulses();
		t_unmapped();
		t_busy();
		t_crc();
		t_protect();
		t_compare();
		t_pmbus();
		finish_test();
	end

	initial
	begin
		#500000;
		failures++;
		finish_test();
	end
endmodule

`default_nettype wire

// [sim/host_reg_model.sv]
// host-side model of the register port, one word per access
`timescale 1ns/1ps
`default_nettype none

module host_reg_model (
	// clock
	input wire logic core_clk_i,
	// request toward the bank
	output var trig_status_pkg::reg_req_t req_o,
	// answer from the bank
	input wire logic [trig_status_pkg::DATA_W-1:0] rdata_i,
	input wire logic rvalid_i
);
	import trig_status_pkg::*;

	initial req_o = '0;

	task automatic access(input logic pm, input logic [7:0] page,
		input logic [7:0] addr, input logic wr, input logic [15:0] wdata,
		output logic [15:0] rdata, output logic got);
		got = 1'h0;
		rdata = 'x;
		@(posedge core_clk_i);
		#1;
		// pmbus access carries the page with the command code
		req_o = '{addr, pm, page, wr, !wr, wdata};
		@(posedge core_clk_i);
		#1;
		// released address, page and data lines show inverted values and wr and rd drop to 0, never a stale request
		req_o = '{~addr, pm, ~page, 1'h0, 1'h0, ~wdata};
		// the taking edge launched the answer; rvalid_i stands one cycle only, rdata_i holds until the next read
		got = !wr && (rvalid_i === 1'h1);
		rdata = got ? rdata_i : 'x;
	endtask
endmodule

`default_nettype wire
